// [rtl/pssx_exec.sv]
// Execution datapath for product shift, square-add, square-minus, store status and subtract.
// Assumes data memory answers a read in the same cycle as the registered address.
//
// What this block does
// - Product output shifted by two-bit mode field.
// - Load-status to word one also sets mode.
// - Set-shift-mode takes one cycle plus wait states.
// - Direct 7-bit offset; indirect pointer updates, next pointer.
// - Square-add: add shifted product, square operand.
// - Square-minus: subtract shifted product, square operand.
// - Square updates honour saturation, set overflow, carry.
// - Arithmetic cycle counts by operand and code place.
// - Store-status cycle counts, external and repeated.
// - Direct store-status always writes data page zero.
// - Subtract operand shifted 0 to 15, or 16.
// - Low bits zero, high bits follow sign mode.
// - Short immediate: unshifted 8-bit, unsigned, never repeated.
// - Long immediate: second word, shifted, subtracted.
// - Subtract carry clears on borrow, sets otherwise.
// - Shift-16 subtract only clears carry on borrow.
// - Program counter advances before the operation.
// - Long immediate occupies two words, others one.
// - Right-six mode gives 128 accumulations of headroom.
// - Set-shift-mode copies instruction bits 1:0.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "pssx_regs.svh"

module pssx_exec (
  // Clock and reset.
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // Instruction issue.
  input  wire logic                  instr_valid,
  input  wire pssx_pkg::pssx_req_t   instr_req,
  output logic                       instr_ready,
  output logic                       instr_done,
  output logic                       busy,
  output logic [15:0]                pc,
  // Data memory.
  output pssx_pkg::pssx_dmem_t       dm_out,
  input  wire logic [15:0]           dm_rdata,
  // Register port.
  input  wire pssx_pkg::pssx_rbus_t  rbus,
  output logic [15:0]                rd_data
);
  import pssx_pkg::*;

  pssx_state_t state_ff;
  pssx_op_t    op_ff;
  pssx_req_t   req_ff;
  pssx_tim_t   tim_ff;
  logic [8:0]  iter_ff;
  logic [4:0]  cyc_ff;
  logic [4:0]  tail_ff;
  logic [15:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [15:0] pc_ff;
  logic [15:0] aux_ff [8];
  logic [31:0] acc_ff;
  logic [31:0] product_register_ff;
  logic [15:0] multiplicand_register_ff;
  logic [1:0]  pm_ff;
  logic        sxm_ff;
  logic        c_ff;
  logic        ovm_ff;
  logic        ov_ff;
  logic [8:0]  dp_ff;
  logic [2:0]  arp_ff;
  logic        done_ff;
  logic [15:0] rdata_ff;

  pssx_op_t    nxt_op;
  pssx_tim_t   nxt_tim;
  logic [8:0]  nxt_iter;
  logic        accept;
  logic        fire;
  logic        last_iter;
  logic        mem_op;
  logic        indirect;
  logic [15:0] nxt_aux_val;
  logic [2:0]  nxt_arp;
  logic [15:0] nxt_addr;
  logic [31:0] opnd;
  logic        is_sub;
  logic        arith_op;
  pssx_alu_t   alu_res;
  logic        nxt_c;
  logic [31:0] square;

  function automatic pssx_op_t decode_op(input logic [15:0] w);
    pssx_op_t r;
    r = OP_NONE;
    if (w[15:8] == `PSSX_OPC_SQUARE_ADD_OP) begin
      r = OP_SQUARE_ADD_OP;
    end else if (w[15:8] == `PSSX_OPC_SQUARE_MINUS_OP) begin
      r = OP_SQUARE_MINUS_OP;
    end else if (w[15:8] == `PSSX_OPC_SUB16) begin
      r = OP_SUB16;
    end else if (w[15:8] == `PSSX_OPC_SUBK) begin
      r = OP_SUBK;
    end else if (w[15:12] == `PSSX_OPC_SUBSH) begin
      r = OP_SUB;
    end else if (w[15:8] == `PSSX_OPC_SST0) begin
      r = OP_SST0;
    end else if (w[15:8] == `PSSX_OPC_SST1) begin
      r = OP_SST1;
    end else if (w[15:8] == `PSSX_OPC_LST1) begin
      r = OP_LST1;
    end else if (w[15:8] == `PSSX_OPC_BF) begin
      if (w[7:2] == 6'h00) begin
        r = OP_SPM;
      end else if (w[7:4] == `PSSX_OPC_SUBLK) begin
        r = OP_SUBLK;
      end
    end
    return r;
  endfunction : decode_op

  function automatic logic reads_mem(input pssx_op_t op);
    return (op == OP_SQUARE_ADD_OP) || (op == OP_SQUARE_MINUS_OP) || (op == OP_SUB) || (op == OP_SUB16) ||
           (op == OP_LST1);
  endfunction : reads_mem

  function automatic logic is_sst(input pssx_op_t op);
    return (op == OP_SST0) || (op == OP_SST1);
  endfunction : is_sst

  // Per-iteration cycles and fixed trailing cycles; total is n * per + fix.
  function automatic pssx_tim_t timing(input pssx_op_t op, input pssx_req_t q,
                                       input logic single);
    pssx_tim_t t;
    logic      oe;
    logic      same;
    t.per = 5'h1;
    t.fix = q.code_ext ? 5'(q.pwait) : 5'h0;
    oe    = q.opnd_ext && (reads_mem(op) || is_sst(op));
    same  = q.same_block && !oe && !q.code_ext && (reads_mem(op) || is_sst(op));
    if (op == OP_SUBLK) begin
      t.per = 5'h2;
      t.fix = q.code_ext ? 5'({q.pwait, 1'b0}) : 5'h0;
    end else if (reads_mem(op)) begin
      t.per = oe ? 5'(q.dwait) + 5'h1 : 5'h1;
      if (q.code_ext) begin
        t.fix = oe ? 5'(q.pwait) + 5'h1 : 5'(q.pwait);
      end else begin
        t.fix = same ? 5'h1 : 5'h0;
      end
    end else if (is_sst(op)) begin
      t.per = oe ? 5'(q.dwait) + 5'h2 : 5'h1;
      if (q.code_ext) begin
        t.fix = oe ? 5'(q.pwait) + 5'h2 : 5'(q.pwait);
      end else if (same) begin
        t.fix = single ? 5'h1 : 5'h2;
      end else begin
        t.fix = 5'h0;
      end
    end
    return t;
  endfunction : timing

  // Product shifter; the right-six setting leaves headroom for 128 accumulations.
  function automatic logic [31:0] prod_shift(input logic [31:0] p, input logic [1:0] pm);
    logic [31:0] r;
    unique case (pm)
      `PSSX_PM_NONE: r = p;
      `PSSX_PM_L1:   r = {p[30:0], 1'b0};
      `PSSX_PM_L4:   r = {p[27:0], 4'h0};
      `PSSX_PM_R6:   r = {{6{p[31]}}, p[31:6]};
    endcase
    return r;
  endfunction : prod_shift

  function automatic logic [31:0] ext_shift(input logic [15:0] d, input logic sign_extend_mode,
                                            input logic [4:0] sh);
    logic [31:0] e;
    e = sign_extend_mode ? {{16{d[15]}}, d} : {16'h0000, d};
    return e << sh;
  endfunction : ext_shift

  function automatic logic [15:0] rev16(input logic [15:0] a);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) begin
      r[i] = a[15 - i];
    end
    return r;
  endfunction : rev16

  function automatic logic [15:0] aux_next(input logic [15:0] a, input logic [15:0] x,
                                           input logic [2:0] upd);
    logic [15:0] r;
    case (upd)
      3'h0:    r = a;
      3'h1:    r = a - 16'h0001;
      3'h2:    r = a + 16'h0001;
      3'h4:    r = rev16(rev16(a) - rev16(x));
      3'h5:    r = a - x;
      3'h6:    r = a + x;
      3'h7:    r = rev16(rev16(a) + rev16(x));
      default: r = a;
    endcase
    return r;
  endfunction : aux_next

  // Addressed operand: bit 7 picks direct page-plus-offset (page zero for status stores) or the current pointer.
  function automatic logic [15:0] op_addr(input logic [15:0] w, input logic store_status_op,
                                          input logic [8:0] dp, input logic [15:0] ptr);
    logic [15:0] r;
    if (w[7]) begin
      r = ptr;
    end else if (store_status_op) begin
      r = {9'h000, w[6:0]};
    end else begin
      r = {dp, w[6:0]};
    end
    return r;
  endfunction : op_addr

  function automatic pssx_alu_t alu_add(input logic [31:0] a, input logic [31:0] b,
                                        input logic sub, input logic overflow_saturate_mode);
    logic [32:0] raw;
    pssx_alu_t   r;
    raw   = sub ? ({1'b0, a} + {1'b0, ~b} + 33'h1) : ({1'b0, a} + {1'b0, b});
    r.ovf = sub ? ((a[31] != b[31]) && (raw[31] != a[31]))
                : ((a[31] == b[31]) && (raw[31] != a[31]));
    r.carry = raw[32];
    if (r.ovf && overflow_saturate_mode) begin
      r.sum = a[31] ? 32'h80000000 : 32'h7FFFFFFF;
    end else begin
      r.sum = raw[31:0];
    end
    return r;
  endfunction : alu_add

  function automatic logic [15:0] st0_word(input logic [2:0] aux_pointer, input logic ov,
                                           input logic overflow_saturate_mode, input logic [8:0] dp);
    logic [15:0] w;
    w = 16'h0000;
    w[`PSSX_ST0_ARP_MSB:`PSSX_ST0_ARP_LSB] = aux_pointer;
    w[`PSSX_ST0_OV_BIT]  = ov;
    w[`PSSX_ST0_OVM_BIT] = overflow_saturate_mode;
    w[`PSSX_ST0_DP_MSB:`PSSX_ST0_DP_LSB] = dp;
    return w;
  endfunction : st0_word

  function automatic logic [15:0] st1_word(input logic sign_extend_mode, input logic c,
                                           input logic [1:0] pm);
    logic [15:0] w;
    w = 16'h0000;
    w[`PSSX_ST1_SXM_BIT] = sign_extend_mode;
    w[`PSSX_ST1_C_BIT]   = c;
    w[`PSSX_ST1_PM_MSB:`PSSX_ST1_PM_LSB] = pm;
    return w;
  endfunction : st1_word

  assign instr_ready = (state_ff == ST_IDLE);
  assign busy        = (state_ff != ST_IDLE);
  assign instr_done  = done_ff;
  assign pc          = pc_ff;
  assign rd_data     = rdata_ff;
  assign accept      = instr_valid && (state_ff == ST_IDLE);
  assign nxt_op      = decode_op(instr_req.word);
  // The short immediate form ignores any repeat count.
  assign nxt_iter    = (nxt_op == OP_SUBK) ? 9'h001 : {1'b0, instr_req.repeat_op} + 9'h001;
  assign nxt_tim     = timing(nxt_op, instr_req, nxt_iter == 9'h001);
  assign fire        = (state_ff == ST_RUN) && (cyc_ff == 5'h01);
  assign last_iter   = (iter_ff == 9'h001);
  assign mem_op      = reads_mem(op_ff) || is_sst(op_ff);
  assign indirect    = req_ff.word[7];
  assign nxt_aux_val = aux_next(aux_ff[arp_ff], aux_ff[0], req_ff.word[6:4]);
  assign nxt_arp     = req_ff.word[3] ? req_ff.word[2:0] : arp_ff;
  assign nxt_addr    = (nxt_arp == arp_ff) ? nxt_aux_val : aux_ff[nxt_arp];
  assign dm_out.addr  = addr_ff;
  assign dm_out.wdata = wdata_ff;
  assign dm_out.rd    = (state_ff == ST_RUN) && reads_mem(op_ff);
  assign dm_out.wr    = fire && is_sst(op_ff);
  assign square       = 32'($signed(dm_rdata) * $signed(dm_rdata));

  always_comb begin
    opnd   = 32'h00000000;
    is_sub = 1'b1;
    case (op_ff)
      OP_SQUARE_ADD_OP: begin
        opnd   = prod_shift(product_register_ff, pm_ff);
        is_sub = 1'b0;
      end
      OP_SQUARE_MINUS_OP:  opnd = prod_shift(product_register_ff, pm_ff);
      OP_SUB:   opnd = ext_shift(dm_rdata, sxm_ff, {1'b0, req_ff.word[11:8]});
      OP_SUB16: opnd = ext_shift(dm_rdata, sxm_ff, `PSSX_SHIFT16);
      OP_SUBK:  opnd = {24'h000000, req_ff.word[7:0]};
      OP_SUBLK: opnd = ext_shift(req_ff.ext_word, sxm_ff, {1'b0, req_ff.word[3:0]});
      default:  opnd = 32'h00000000;
    endcase
  end

  assign alu_res  = alu_add(acc_ff, opnd, is_sub, ovm_ff);
  assign arith_op = (op_ff == OP_SQUARE_ADD_OP) || (op_ff == OP_SQUARE_MINUS_OP) || (op_ff == OP_SUB) ||
                    (op_ff == OP_SUB16) || (op_ff == OP_SUBK) || (op_ff == OP_SUBLK);
  // A shift-16 subtract may only pull the carry low.
  assign nxt_c    = (op_ff == OP_SUB16) ? (alu_res.carry & c_ff) : alu_res.carry;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: if (accept) begin
          state_ff <= ST_RUN;
        end
        ST_RUN: if (fire && last_iter) begin
          state_ff <= (tim_ff.fix != 5'h00) ? ST_TAIL : ST_IDLE;
        end
        ST_TAIL: if (tail_ff == 5'h01) begin
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      iter_ff <= 9'h000;
      cyc_ff  <= 5'h00;
      tail_ff <= 5'h00;
      done_ff <= 1'b0;
    end else begin
      done_ff <= ((state_ff == ST_RUN) && fire && last_iter && (tim_ff.fix == 5'h00)) ||
                 ((state_ff == ST_TAIL) && (tail_ff == 5'h01));
      if (accept) begin
        iter_ff <= nxt_iter;
        cyc_ff  <= nxt_tim.per;
        tail_ff <= nxt_tim.fix;
      end else if (fire) begin
        iter_ff <= iter_ff - 9'h001;
        cyc_ff  <= tim_ff.per;
      end else if (state_ff == ST_RUN) begin
        cyc_ff <= cyc_ff - 5'h01;
      end else if (state_ff == ST_TAIL) begin
        tail_ff <= tail_ff - 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      op_ff    <= OP_NONE;
      req_ff   <= '0;
      tim_ff   <= '0;
      addr_ff  <= 16'h0000;
      wdata_ff <= 16'h0000;
    end else if (accept) begin
      op_ff    <= nxt_op;
      req_ff   <= instr_req;
      tim_ff   <= nxt_tim;
      addr_ff  <= op_addr(instr_req.word, is_sst(nxt_op), dp_ff, aux_ff[arp_ff]);
      wdata_ff <= (nxt_op == OP_SST0) ? st0_word(arp_ff, ov_ff, ovm_ff, dp_ff)
                                      : st1_word(sxm_ff, c_ff, pm_ff);
    end else if (fire && indirect) begin
      addr_ff <= nxt_addr;
    end
  end

  // Program counter moves on at acceptance, ahead of any operation.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pc_ff <= `PSSX_RST_PC;
    end else if (accept) begin
      pc_ff <= pc_ff + ((nxt_op == OP_SUBLK) ? 16'h0002 : 16'h0001);
    end else if (rbus.wr && (rbus.addr == `PSSX_A_PC)) begin
      pc_ff <= rbus.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < 8; i++) begin
        aux_ff[i] <= 16'h0000;
      end
    end else if (fire && indirect && mem_op) begin
      aux_ff[arp_ff] <= nxt_aux_val;
    end else if (rbus.wr && (rbus.addr[4:3] == `PSSX_A_AUX_BASE >> 3)) begin
      aux_ff[rbus.addr[2:0]] <= rbus.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      acc_ff  <= 32'h00000000;
      product_register_ff <= 32'h00000000;
      multiplicand_register_ff <= 16'h0000;
    end else if (fire) begin
      if (arith_op) begin
        acc_ff <= alu_res.sum;
      end
      if ((op_ff == OP_SQUARE_ADD_OP) || (op_ff == OP_SQUARE_MINUS_OP)) begin
        multiplicand_register_ff <= dm_rdata;
        product_register_ff <= square;
      end
    end else if (rbus.wr) begin
      // Software preloads land only in a cycle in which no operation completes.
      case (rbus.addr)
        `PSSX_A_SUM_LO:  acc_ff[15:0]   <= rbus.wdata;
        `PSSX_A_SUM_HI:  acc_ff[31:16]  <= rbus.wdata;
        `PSSX_A_PROD_LO: product_register_ff[15:0]  <= rbus.wdata;
        `PSSX_A_PROD_HI: product_register_ff[31:16] <= rbus.wdata;
        `PSSX_A_MULT:    multiplicand_register_ff        <= rbus.wdata;
        default:         multiplicand_register_ff        <= multiplicand_register_ff;
      endcase
    end
  end

  // Status word one: hardware updates take priority over a same-cycle software write.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pm_ff  <= `PSSX_RST_PM;
      sxm_ff <= `PSSX_RST_SXM;
      c_ff   <= `PSSX_RST_C;
    end else if (fire && (op_ff == OP_SPM)) begin
      pm_ff <= req_ff.word[1:0];
    end else if (fire && (op_ff == OP_LST1)) begin
      pm_ff  <= dm_rdata[`PSSX_ST1_PM_MSB:`PSSX_ST1_PM_LSB];
      sxm_ff <= dm_rdata[`PSSX_ST1_SXM_BIT];
      c_ff   <= dm_rdata[`PSSX_ST1_C_BIT];
    end else if (fire && arith_op) begin
      c_ff <= nxt_c;
    end else if (rbus.wr && (rbus.addr == `PSSX_A_ST1)) begin
      pm_ff  <= rbus.wdata[`PSSX_ST1_PM_MSB:`PSSX_ST1_PM_LSB];
      sxm_ff <= rbus.wdata[`PSSX_ST1_SXM_BIT];
      c_ff   <= rbus.wdata[`PSSX_ST1_C_BIT];
    end
  end

  // Status word zero: an overflow in the same cycle as a software clear still lands.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ovm_ff <= `PSSX_RST_OVM;
      dp_ff  <= `PSSX_RST_DP;
      arp_ff <= `PSSX_RST_ARP;
      ov_ff  <= 1'b0;
    end else begin
      if (rbus.wr && (rbus.addr == `PSSX_A_ST0)) begin
        ovm_ff <= rbus.wdata[`PSSX_ST0_OVM_BIT];
        dp_ff  <= rbus.wdata[`PSSX_ST0_DP_MSB:`PSSX_ST0_DP_LSB];
        ov_ff  <= rbus.wdata[`PSSX_ST0_OV_BIT] | (fire && arith_op && alu_res.ovf);
      end else if (fire && arith_op && alu_res.ovf) begin
        ov_ff <= 1'b1;
      end
      if (fire && indirect && mem_op) begin
        arp_ff <= nxt_arp;
      end else if (rbus.wr && (rbus.addr == `PSSX_A_ST0)) begin
        arp_ff <= rbus.wdata[`PSSX_ST0_ARP_MSB:`PSSX_ST0_ARP_LSB];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_ff <= 16'h0000;
    end else if (rbus.rd) begin
      if (rbus.addr[4:3] == `PSSX_A_AUX_BASE >> 3) begin
        rdata_ff <= aux_ff[rbus.addr[2:0]];
      end else begin
        case (rbus.addr)
          `PSSX_A_ST0:     rdata_ff <= st0_word(arp_ff, ov_ff, ovm_ff, dp_ff);
          `PSSX_A_ST1:     rdata_ff <= st1_word(sxm_ff, c_ff, pm_ff);
          `PSSX_A_SUM_LO:  rdata_ff <= acc_ff[15:0];
          `PSSX_A_SUM_HI:  rdata_ff <= acc_ff[31:16];
          `PSSX_A_PROD_LO: rdata_ff <= product_register_ff[15:0];
          `PSSX_A_PROD_HI: rdata_ff <= product_register_ff[31:16];
          `PSSX_A_MULT:    rdata_ff <= multiplicand_register_ff;
          `PSSX_A_PC:      rdata_ff <= pc_ff;
          `PSSX_A_STAT:    rdata_ff <= {13'h0000, state_ff == ST_TAIL, busy, done_ff};
          default:         rdata_ff <= 16'h0000;
        endcase
      end
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

endmodule : pssx_exec

// [rtl/pssx_pkg.sv]
// Types shared by the execution block and its bench.
// Assumes the constants of pssx_regs.svh.
package pssx_pkg;
  typedef struct packed {
    logic [15:0] word;
    logic [15:0] ext_word;
    logic [7:0]  repeat_op;
    logic        code_ext;
    logic        opnd_ext;
    logic        same_block;
    logic [3:0]  pwait;
    logic [3:0]  dwait;
  } pssx_req_t;
  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [15:0] wdata;
  } pssx_dmem_t;
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pssx_rbus_t;
  typedef struct packed {
    logic [31:0] sum;
    logic        carry;
    logic        ovf;
  } pssx_alu_t;
  typedef struct packed {
    logic [4:0] per;
    logic [4:0] fix;
  } pssx_tim_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_TAIL = 2'b10
  } pssx_state_t;
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000, OP_SPM = 4'b0001, OP_SQUARE_ADD_OP = 4'b0010, OP_SQUARE_MINUS_OP = 4'b0011,
    OP_SUB = 4'b0100, OP_SUB16 = 4'b0101, OP_SUBK = 4'b0110, OP_SUBLK = 4'b0111,
    OP_SST0 = 4'b1000, OP_SST1 = 4'b1001, OP_LST1 = 4'b1010
  } pssx_op_t;
endpackage : pssx_pkg

// [rtl/pssx_regs.svh]
// Offsets, field positions, reset values, opcodes and shift codes of the execution block.
// Assumes a 16-bit instruction word and a 5-bit register port address.
`ifndef PSSX_REGS_SVH
`define PSSX_REGS_SVH
`define PSSX_A_ST0        5'h00
`define PSSX_A_ST1        5'h01
`define PSSX_A_SUM_LO     5'h02
`define PSSX_A_SUM_HI     5'h03
`define PSSX_A_PROD_LO    5'h04
`define PSSX_A_PROD_HI    5'h05
`define PSSX_A_MULT       5'h06
`define PSSX_A_PC         5'h07
`define PSSX_A_STAT       5'h08
`define PSSX_A_AUX_BASE   5'h10
`define PSSX_ST0_ARP_MSB  15
`define PSSX_ST0_ARP_LSB  13
`define PSSX_ST0_OV_BIT   12
`define PSSX_ST0_OVM_BIT  11
`define PSSX_ST0_DP_MSB   8
`define PSSX_ST0_DP_LSB   0
`define PSSX_ST1_SXM_BIT  10
`define PSSX_ST1_C_BIT    9
`define PSSX_ST1_PM_MSB   1
`define PSSX_ST1_PM_LSB   0
`define PSSX_RST_PM       2'h0
`define PSSX_RST_SXM      1'h1
`define PSSX_RST_C        1'h1
`define PSSX_RST_OVM      1'h0
`define PSSX_RST_DP       9'h000
`define PSSX_RST_ARP      3'h0
`define PSSX_RST_PC       16'h0000
`define PSSX_OPC_SQUARE_ADD_OP     8'h52
`define PSSX_OPC_SQUARE_MINUS_OP     8'h53
`define PSSX_OPC_SUB16    8'h65
`define PSSX_OPC_SUBK     8'hBA
`define PSSX_OPC_BF       8'hBF
`define PSSX_OPC_SUBSH    4'h3
`define PSSX_OPC_SUBLK    4'hA
`define PSSX_OPC_SST0     8'h8E
`define PSSX_OPC_SST1     8'h8F
`define PSSX_OPC_LST1     8'h0F
`define PSSX_PM_NONE      2'h0
`define PSSX_PM_L1        2'h1
`define PSSX_PM_L4        2'h2
`define PSSX_PM_R6        2'h3
`define PSSX_SHIFT16      5'h10
`endif

// [tb/pssx_exec_monitor.sv]
// Timing, pc and status store checks of pssx_exec.
// Assumes a bind to pssx_exec; sees only its ports.
`timescale 1ns/10ps
module pssx_exec_monitor (
  // Clock and reset.
  input wire logic                 ref_clk,
  input wire logic                 srst,
  // Instruction port.
  input wire logic                 instr_valid,
  input wire pssx_pkg::pssx_req_t  instr_req,
  input wire logic                 instr_ready,
  input wire logic                 instr_done,
  input wire logic                 busy,
  input wire logic [15:0]          pc,
  // Data memory.
  input wire pssx_pkg::pssx_dmem_t dm_out
);
  import pssx_pkg::*;
  logic       tk;
  logic       lk;
  logic       ie;
  logic [7:0] hi;
  logic       sst_dir_ff;
  assign tk = instr_valid && instr_ready;
  assign hi = instr_req.word[15:8];
  assign lk = instr_req.word[15:4] == 12'hBFA;
  // Internal code and operand, no repeat.
  assign ie = !instr_req.code_ext && !instr_req.opnd_ext && instr_req.repeat_op == 8'h00;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sst_dir_ff <= 1'b0;
    end else if (tk) begin
      sst_dir_ff <= hi[7:1] == 7'h47 && !instr_req.word[7];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  pc_one_a: assert property (
    tk && !lk |=> pc == $past(pc) + 16'h0001) else $error("pc step not one");
  pc_two_a: assert property (
    tk && lk |=> pc == $past(pc) + 16'h0002) else $error("pc step not two");
  spm_time_a: assert property (
    tk && hi == 8'hBF && instr_req.word[7:2] == 6'h00 && ie |=> busy ##1 instr_done && !busy)
    else $error("mode set not one cycle");
  sqr_time_a: assert property (
    tk && hi[7:1] == 7'h29 && ie && !instr_req.same_block |=> busy ##1 instr_done)
    else $error("square not one cycle");
  sub_block_a: assert property (
    tk && hi[7:4] == 4'h3 && ie && instr_req.same_block |=> busy [*2] ##1 instr_done)
    else $error("shared block subtract not two cycles");
  sst_time_a: assert property (
    tk && hi == 8'h8E && ie && !instr_req.same_block |=> dm_out.wr && busy ##1 instr_done)
    else $error("status store not one cycle");
  sst_page_a: assert property (
    dm_out.wr && sst_dir_ff |-> dm_out.addr[15:7] == 9'h000) else $error("store off page");
  simm_once_a: assert property (
    tk && hi == 8'hBA && !instr_req.code_ext |=> busy ##1 instr_done)
    else $error("short immediate repeated");
  limm_time_a: assert property (
    tk && lk && !instr_req.code_ext |=> busy [*2] ##1 instr_done)
    else $error("long immediate not two cycles");
endmodule : pssx_exec_monitor

// [tb/pssx_exec_tb_top.sv]
// Directed bench of pssx_exec through its instruction and register ports.
// Assumes the bench plays data memory with a combinational read word.
`timescale 1ns/10ps
`include "pssx_regs.svh"
module pssx_exec_tb_top;
  import pssx_pkg::*;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        instr_valid = 1'b0;
  pssx_req_t   instr_req = '0;
  pssx_rbus_t  rbus = '0;
  logic [15:0] dm_rdata = 16'h0000;
  logic        instr_ready, instr_done, busy;
  logic [15:0] pc, rd_data, v, wa, wd;
  logic [31:0] q;
  pssx_dmem_t  dm_out;
  int          err_total = 0, checked = 0, cyc = 0, n;
  logic [31:0] sh_t [4] = '{32'hFFFFF000, 32'hFFFFE000, 32'hFFFF0000, 32'hFFFFFFC0};
  pssx_exec dut (.ref_clk(ref_clk), .srst(srst), .instr_valid(instr_valid),
    .instr_req(instr_req), .instr_ready(instr_ready), .instr_done(instr_done), .busy(busy),
    .pc(pc), .dm_out(dm_out), .dm_rdata(dm_rdata), .rbus(rbus), .rd_data(rd_data));
  always #2 ref_clk = ~ref_clk;
  task automatic test_done;
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      test_done;
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    rbus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    rbus <= '0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    rbus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    rbus <= '0;
    #1;
    d = rd_data;
  endtask : rd
  task automatic ws(input logic [4:0] a, input logic [31:0] d);
    wr(a, d[15:0]);
    wr(a + 5'h01, d[31:16]);
  endtask : ws
  task automatic rs(input logic [4:0] a, output logic [31:0] d);
    logic [15:0] l, h;
    rd(a, l);
    rd(a + 5'h01, h);
    d = {h, l};
  endtask : rs
  // Issues one instruction and counts its busy cycles; d is operand and second word.
  task automatic ex(input logic [15:0] w, input logic [15:0] d, input logic [3:0] p,
                    input logic [7:0] r, input logic sb, output int c);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    dm_rdata <= d;
    instr_req <= '{word: w, ext_word: d, repeat_op: r, code_ext: p != 4'h0, opnd_ext: 1'b0,
                   same_block: sb, pwait: p, dwait: 4'h0};
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    c = 0;
    #1;
    while (instr_done !== 1'b1 && c < 50) begin
      if (busy === 1'b1) c++;
      if (dm_out.wr === 1'b1) begin
        wa = dm_out.addr;
        wd = dm_out.wdata;
      end
      @(posedge ref_clk);
      #1;
    end
  endtask : ex
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    rd(`PSSX_A_ST1, v);
    cmp(v, 32'h0600);
    for (int m = 0; m < 4; m++) begin
      ex({14'h2FC0, m[1:0]}, 16'h0000, 4'h0, 8'h00, 1'b0, n);
      cmp(n, 1);
      rd(`PSSX_A_ST1, v);
      cmp(v, {14'h0180, m[1:0]});
    end
    ex(16'hBF00, 16'h0000, 4'h3, 8'h00, 1'b0, n);
    cmp(n, 4);
    for (int m = 0; m < 4; m++) begin
      wr(`PSSX_A_ST1, {14'h0180, m[1:0]});
      ws(`PSSX_A_PROD_LO, 32'hFFFFF000);
      ws(`PSSX_A_SUM_LO, 32'h0);
      ex(16'h5205, 16'hFFFD, 4'h0, 8'h00, 1'b0, n);
      rs(`PSSX_A_SUM_LO, q);
      cmp(q, sh_t[m]);
      rs(`PSSX_A_PROD_LO, q);
      cmp(q, 32'h9);
    end
    rd(`PSSX_A_MULT, v);
    cmp(v, 32'hFFFD);
    wr(`PSSX_A_ST1, 16'h0600);
    ws(`PSSX_A_PROD_LO, 32'h190);
    ws(`PSSX_A_SUM_LO, 32'h1450);
    ex(16'h5309, 16'h0008, 4'h0, 8'h00, 1'b0, n);
    rs(`PSSX_A_SUM_LO, q);
    cmp(q, 32'h12C0);
    rs(`PSSX_A_PROD_LO, q);
    cmp(q, 32'h40);
    for (int s = 0; s < 2; s++) begin
      wr(`PSSX_A_ST1, {5'h00, s[0], 10'h200});
      ws(`PSSX_A_SUM_LO, 32'h0);
      ex(16'h3005, 16'hFFFF, 4'h0, 8'h00, 1'b0, n);
      rs(`PSSX_A_SUM_LO, q);
      cmp(q, s ? 32'h1 : 32'hFFFF0001);
      rd(`PSSX_A_ST1, v);
      cmp(v[9], 1'b0);
    end
    ws(`PSSX_A_SUM_LO, 32'h10000);
    ex(16'h3F05, 16'h0001, 4'h0, 8'h00, 1'b1, n);
    cmp(n, 2);
    rs(`PSSX_A_SUM_LO, q);
    cmp(q, 32'h8000);
    rd(`PSSX_A_ST1, v);
    cmp(v[9], 1'b1);
    for (int b = 0; b < 2; b++) begin
      wr(`PSSX_A_ST1, b ? 16'h0200 : 16'h0000);
      ws(`PSSX_A_SUM_LO, b ? 32'h0 : 32'h10000);
      ex(16'h6505, 16'h0001, 4'h0, 8'h00, 1'b0, n);
      rs(`PSSX_A_SUM_LO, q);
      cmp(q, b ? 32'hFFFF0000 : 32'h0);
      rd(`PSSX_A_ST1, v);
      cmp(v[9], 1'b0);
    end
    wr(`PSSX_A_ST1, 16'h0600);
    ws(`PSSX_A_SUM_LO, 32'h100);
    ex(16'hBAF0, 16'h0000, 4'h0, 8'h05, 1'b0, n);
    cmp(n, 1);
    rs(`PSSX_A_SUM_LO, q);
    cmp(q, 32'h10);
    wr(`PSSX_A_ST1, 16'h0000);
    ws(`PSSX_A_SUM_LO, 32'hFFFF);
    v = pc;
    ex(16'hBFA4, 16'h0FFF, 4'h0, 8'h00, 1'b0, n);
    cmp(pc, v + 16'h0002);
    rs(`PSSX_A_SUM_LO, q);
    cmp(q, 32'hF);
    rd(`PSSX_A_ST1, v);
    cmp(v[9], 1'b1);
    wr(`PSSX_A_ST0, 16'h0800);
    ws(`PSSX_A_SUM_LO, 32'h80000000);
    ex(16'hBA01, 16'h0000, 4'h0, 8'h00, 1'b0, n);
    rs(`PSSX_A_SUM_LO, q);
    cmp(q, 32'h80000000);
    rd(`PSSX_A_ST0, v);
    cmp(v[12], 1'b1);
    wr(`PSSX_A_ST0, 16'h0006);
    ex(16'h8E60, 16'h0000, 4'h0, 8'h00, 1'b0, n);
    cmp(wa, 32'h0060);
    cmp(wd, 32'h0006);
    wr(`PSSX_A_ST0, 16'h2000);
    wr(5'h11, 16'h0030);
    ex(16'h8FAB, 16'h0000, 4'h0, 8'h00, 1'b0, n);
    cmp(wa, 32'h0030);
    rd(5'h11, v);
    cmp(v, 32'h0031);
    rd(`PSSX_A_ST0, v);
    cmp(v[15:13], 3'h3);
    ex(16'h0F10, 16'h0602, 4'h0, 8'h00, 1'b0, n);
    rd(`PSSX_A_ST1, v);
    cmp(v[1:0], 2'h2);
    test_done;
  end
endmodule : pssx_exec_tb_top
bind pssx_exec pssx_exec_monitor u_mon (.ref_clk(ref_clk), .srst(srst),
  .instr_valid(instr_valid), .instr_req(instr_req), .instr_ready(instr_ready),
  .instr_done(instr_done), .busy(busy), .pc(pc), .dm_out(dm_out));
